// [logic/cmosd_clock_mode.v]
// clock mode control with oscillation stop and re-oscillation detection
// Functional notes
// - sub oscillator runs only when enabled
// - divide field selects 1, 2, 4, 16
// - divide-by-eight bit overrides the field
// - sub select picks sub clock source
// - main stop bit turns main oscillator off
// - pll on plus select picks pll
// - on-chip select picks on-chip oscillator
// - all clocks off enters stop mode
// - wait instruction enters wait mode
// - hardware interrupt exits stop or wait
// - detector senses stop and re-oscillation
// - detector active only when enabled
// - response bit picks reset or interrupt
// - stop detection needs main at least 2 MHz
// - stop in reset mode halts until reset
// - re-oscillation in reset mode also halts
// - interrupt mode stop switches to on-chip unless sub or pll is selected
// - set flag blocks further detection interrupts
`timescale 1ns/100ps
`include "cmosd_regs.vh"
module cmosd_clock_mode #(
  parameter WIN_CYC = `CMOSD_WIN_CYC
)(
  input wire ref_clk,
  input wire rstn,
  input wire mainOscIn,
  input wire subOscEnable,
  input wire mainOscStop,
  input wire div8Select,
  input wire sysClkSubSelect,
  input wire allClocksOffWr,
  input wire pllSourceSelect,
  input wire divFieldLow,
  input wire divFieldHigh,
  input wire pllOn,
  input wire oscDetectEnable,
  input wire onchipOscSelectWr,
  input wire onchipOscSelectVal,
  input wire oscDetectFlagClr,
  input wire oscDetectResponse,
  input wire waitInstr,
  input wire hwIrq,
  output reg subOscRun_r,
  output reg mainOscRun_r,
  output reg onchipOscRun_r,
  output reg [1:0] cpuClkSrc_r,
  output reg [4:0] cpuDivRatio_r,
  output reg div8Status_r,
  output reg onchipOscSelect_r,
  output reg oscDetectFlag_r,
  output reg mainClkStopped_r,
  output reg oscDetectIrq_r,
  output reg oscStopReset_r,
  output reg [1:0] powerMode_r,
  output wire cpuClkGate
);
  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg div8Force_r;
  wire mainPresent;
  wire stopEv;
  wire reoscEv;
  wire detEvent;
  wire div8Eff;
  wire peripheralOco;

  // divider code to ratio, shared by the output and any later consumer
  function [4:0] divRatio;
    input d8;
    input [1:0] fld;
    begin
      if (d8)
        divRatio = 5'h08;
      else
        case (fld)
          `CMOSD_DIV_1: divRatio = 5'h01;
          `CMOSD_DIV_2: divRatio = 5'h02;
          `CMOSD_DIV_4: divRatio = 5'h04;
          default: divRatio = 5'h10;
        endcase
    end
  endfunction

  cmosd_edge_watch #(
    .WIN_CYC(WIN_CYC),
    .CW(8)
  ) uWatch (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .enable(oscDetectEnable),
    .mainOscIn(mainOscIn),
    .mainPresent_r(mainPresent),
    .stopEvent_r(stopEv),
    .reoscEvent_r(reoscEv)
  );

  // below 2 MHz the window may see no edge; user must keep detection off then
  assign detEvent = oscDetectEnable & (stopEv | reoscEv);

  // stop entry and main stop both force divide by eight until a cycle with neither strobe sees div8Select low
  // the strobe itself counts too, so the ratio is eight in the very cycle of entry
  assign div8Eff = div8Select | div8Force_r | allClocksOffWr | mainOscStop;
  assign peripheralOco = onchipOscRun_r & mainClkStopped_r;

  // cpu clock runs only in run mode
  assign cpuClkGate = (mode_r == `CMOSD_ST_RUN);

  // power mode state machine
  always @*
  begin
    mode_nxt = mode_r;
    case (mode_r)
      `CMOSD_ST_RUN:
      begin
        if (allClocksOffWr)
          mode_nxt = `CMOSD_ST_STOP;
        else if (waitInstr)
          mode_nxt = `CMOSD_ST_WAIT;
      end
      `CMOSD_ST_WAIT, `CMOSD_ST_STOP:
      begin
        if (hwIrq)
          mode_nxt = `CMOSD_ST_RUN;
      end
      `CMOSD_ST_HALT:
        mode_nxt = `CMOSD_ST_HALT;
      default:
        mode_nxt = `CMOSD_ST_RUN;
    endcase
    if (detEvent && !oscDetectResponse)
      mode_nxt = `CMOSD_ST_HALT;
  end

  // halt state is left only by the hardware reset
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_r <= `CMOSD_ST_RUN;
      powerMode_r <= `CMOSD_ST_RUN;
      oscStopReset_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      powerMode_r <= mode_nxt;
      oscStopReset_r <= (mode_nxt == `CMOSD_ST_HALT);
    end
  end

  // detection flags, on-chip select and interrupt request
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      oscDetectFlag_r <= 1'b0;
      mainClkStopped_r <= 1'b0;
      onchipOscSelect_r <= 1'b0;
      oscDetectIrq_r <= 1'b0;
    end
    else
    begin
      oscDetectIrq_r <= 1'b0;
      mainClkStopped_r <= ~mainPresent;
      if (onchipOscSelectWr)
        onchipOscSelect_r <= onchipOscSelectVal;
      // flag blocks repeats, set beats clear
      if (detEvent && oscDetectResponse)
      begin
        // an event in the clear cycle keeps the flag set
        oscDetectFlag_r <= 1'b1;
        if (!oscDetectFlag_r)
        begin
          oscDetectIrq_r <= 1'b1;
          if (stopEv && !sysClkSubSelect && !(pllOn && pllSourceSelect))
            onchipOscSelect_r <= 1'b1;
        end
      end
      else if (oscDetectFlagClr)
        oscDetectFlag_r <= 1'b0;
    end
  end

  // oscillator enables and the divide-by-eight force
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      subOscRun_r <= 1'b0;
      mainOscRun_r <= 1'b1;
      onchipOscRun_r <= 1'b0;
      div8Force_r <= 1'b1;
    end
    else
    begin
      subOscRun_r <= subOscEnable & (mode_nxt != `CMOSD_ST_STOP);
      mainOscRun_r <= ~mainOscStop & (mode_nxt != `CMOSD_ST_STOP) & (mode_nxt != `CMOSD_ST_HALT);
      onchipOscRun_r <= (onchipOscSelect_r | peripheralOco | (stopEv & oscDetectResponse & oscDetectEnable))
        & (mode_nxt != `CMOSD_ST_STOP);
      if (allClocksOffWr || mainOscStop)
        div8Force_r <= 1'b1;
      else if (!div8Select)
        div8Force_r <= 1'b0;
    end
  end

  // cpu source and divider outputs
  // division follows the field every cycle, whatever the source
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cpuClkSrc_r <= `CMOSD_SRC_MAIN;
      cpuDivRatio_r <= 5'h08;
      div8Status_r <= 1'b1;
    end
    else
    begin
      cpuDivRatio_r <= divRatio(div8Eff, {divFieldHigh, divFieldLow});
      div8Status_r <= div8Eff;
      if (sysClkSubSelect)
        cpuClkSrc_r <= `CMOSD_SRC_SUB;
      else if (onchipOscSelect_r)
        cpuClkSrc_r <= `CMOSD_SRC_OCO;
      else if (pllOn && pllSourceSelect)
        cpuClkSrc_r <= `CMOSD_SRC_PLL;
      else
        cpuClkSrc_r <= `CMOSD_SRC_MAIN;
    end
  end
endmodule

// [logic/cmosd_edge_watch.v]
// main clock presence watcher sampled by the reference clock
`timescale 1ns/100ps
`include "cmosd_regs.vh"
module cmosd_edge_watch #(
  parameter WIN_CYC = `CMOSD_WIN_CYC,
  parameter CW = 8
)(
  input wire ref_clk,
  input wire rstn,
  input wire enable,
  input wire mainOscIn,
  output reg mainPresent_r,
  output reg stopEvent_r,
  output reg reoscEvent_r
);
  reg sync1_r;
  reg sync2_r;
  reg last_r;
  reg seen_r;
  reg [CW-1:0] winCnt_r;
  wire edgeNow;
  wire winEnd;
  // last count of a window, cut to the counter width on purpose
  localparam integer WIN_LAST_I = WIN_CYC - 1;
  localparam [CW-1:0] WIN_LAST = WIN_LAST_I[CW-1:0];
  localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

  // two-stage synchroniser; only the second stage is looked at
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      sync1_r <= mainOscIn;
      sync2_r <= sync1_r;
      last_r <= sync2_r;
    end
  end

  assign edgeNow = sync2_r ^ last_r;
  assign winEnd = (winCnt_r == WIN_LAST);

  // edge window judge
  // window judge; presence is assumed at reset so no false re-oscillation at start-up
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      winCnt_r <= {CW{1'b0}};
      seen_r <= 1'b0;
      mainPresent_r <= 1'b1;
      stopEvent_r <= 1'b0;
      reoscEvent_r <= 1'b0;
    end
    else
    begin
      stopEvent_r <= 1'b0;
      reoscEvent_r <= 1'b0;
      if (!enable)
      begin
        winCnt_r <= {CW{1'b0}};
        seen_r <= 1'b0;
      end
      else if (winEnd)
      begin
        winCnt_r <= {CW{1'b0}};
        seen_r <= 1'b0;
        mainPresent_r <= seen_r | edgeNow;
        stopEvent_r <= mainPresent_r & ~(seen_r | edgeNow);
        reoscEvent_r <= ~mainPresent_r & (seen_r | edgeNow);
      end
      else
      begin
        winCnt_r <= winCnt_r + CNT_ONE;
        seen_r <= seen_r | edgeNow;
      end
    end
  end
endmodule

// [logic/cmosd_regs.vh]
// constants for the clock mode and oscillation stop detect block
`ifndef CMOSD_REGS_VH
`define CMOSD_REGS_VH
// cpu divider codes of the two-bit field
`define CMOSD_DIV_1 2'h0
`define CMOSD_DIV_2 2'h1
`define CMOSD_DIV_4 2'h2
`define CMOSD_DIV_16 2'h3
// cpu clock source codes
`define CMOSD_SRC_MAIN 2'h0
`define CMOSD_SRC_PLL 2'h1
`define CMOSD_SRC_OCO 2'h2
`define CMOSD_SRC_SUB 2'h3
// power mode state codes
`define CMOSD_ST_RUN 2'h0
`define CMOSD_ST_WAIT 2'h1
`define CMOSD_ST_STOP 2'h2
`define CMOSD_ST_HALT 2'h3
// main clock edge window, in ref_clk cycles; 2 MHz floor gives many edges per window
`define CMOSD_WIN_NS 2000
`define CMOSD_CLK_NS 100
`define CMOSD_WIN_CYC (`CMOSD_WIN_NS / `CMOSD_CLK_NS)
`endif

// [tb/cmosd_properties.sv]
// checker for the clock mode block outputs
`timescale 1ns/100ps
module cmosd_properties (
  input wire ref_clk,
  input wire rstn,
  input wire allClocksOffWr,
  input wire waitInstr,
  input wire hwIrq,
  input wire oscDetectEnable,
  input wire oscDetectResponse,
  input wire subOscRun_r,
  input wire [4:0] cpuDivRatio_r,
  input wire div8Status_r,
  input wire oscDetectFlag_r,
  input wire oscDetectIrq_r,
  input wire oscStopReset_r,
  input wire [1:0] powerMode_r,
  input wire cpuClkGate
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_stop;
    allClocksOffWr && !hwIrq && powerMode_r == 2'h0 |=> powerMode_r == 2'h2 && div8Status_r && !subOscRun_r;
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry wrong");
  property p_wait;
    waitInstr && !allClocksOffWr && !hwIrq && powerMode_r == 2'h0 |=> powerMode_r == 2'h1;
  endproperty
  a_wait: assert property (p_wait) else $error("wait entry wrong");
  property p_wake;
    hwIrq && (powerMode_r == 2'h1 || powerMode_r == 2'h2) |=> powerMode_r == 2'h0;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_div8;
    div8Status_r |-> cpuDivRatio_r == 5'h08;
  endproperty
  a_div8: assert property (p_div8) else $error("div8 ratio wrong");
  property p_gate;
    cpuClkGate == (powerMode_r == 2'h0);
  endproperty
  a_gate: assert property (p_gate) else $error("gate wrong");
  property p_halt;
    powerMode_r == 2'h3 |=> (powerMode_r == 2'h3 && oscStopReset_r) [*2];
  endproperty
  a_halt: assert property (p_halt) else $error("halt left");
  property p_irq;
    oscDetectIrq_r |-> oscDetectFlag_r && !$past(oscDetectFlag_r) && oscDetectResponse ##1 !oscDetectIrq_r;
  endproperty
  a_irq: assert property (p_irq) else $error("detect irq wrong");
  property p_off;
    !oscDetectEnable && !$past(oscDetectEnable) && !$past(oscDetectEnable, 2) |-> !oscDetectIrq_r && !$rose(oscStopReset_r);
  endproperty
  a_off: assert property (p_off) else $error("detector active");
endmodule
bind cmosd_clock_mode cmosd_properties chk (.ref_clk, .rstn, .allClocksOffWr, .waitInstr, .hwIrq,
  .oscDetectEnable, .oscDetectResponse, .subOscRun_r, .cpuDivRatio_r, .div8Status_r, .oscDetectFlag_r,
  .oscDetectIrq_r, .oscStopReset_r, .powerMode_r, .cpuClkGate);

// [tb/cmosd_xtal_model.sv]
// main crystal oscillator model
`timescale 1ns/100ps
module cmosd_xtal_model #(
  parameter HALF_NS = 75
)(
  input wire run,
  input wire fail,
  output reg oscOut
);
  // stopped crystal rests low, no stale toggling
  initial
  begin
    oscOut = 1'b0;
    forever
    begin
      #(HALF_NS);
      oscOut = (run && !fail) ? !oscOut : 1'b0;
    end
  end
endmodule

// [tb/test_cmosd_clock_mode.sv]
// self-checking bench for the clock mode block
`timescale 1ns/100ps
module test_cmosd_clock_mode;
  reg ref_clk = 0, rstn = 0, subOscEnable = 0, mainOscStop = 0, div8Select = 0, sysClkSubSelect = 0;
  reg allClocksOffWr = 0, pllSourceSelect = 0, divFieldLow = 0, divFieldHigh = 0, pllOn = 0, fail = 0;
  reg oscDetectEnable = 0, onchipOscSelectWr = 0, onchipOscSelectVal = 0, oscDetectFlagClr = 0;
  reg oscDetectResponse = 0, waitInstr = 0, hwIrq = 0;
  reg [31:0] r;
  wire subOscRun_r, mainOscRun_r, onchipOscRun_r, div8Status_r, onchipOscSelect_r, oscDetectFlag_r;
  wire mainClkStopped_r, oscDetectIrq_r, oscStopReset_r, cpuClkGate, mainOscIn;
  wire [1:0] cpuClkSrc_r, powerMode_r;
  wire [4:0] cpuDivRatio_r;
  integer n_errors = 0, cmp_count = 0, k, i;
  cmosd_clock_mode #(.WIN_CYC(8)) dut (.ref_clk, .rstn, .mainOscIn, .subOscEnable, .mainOscStop,
    .div8Select, .sysClkSubSelect, .allClocksOffWr, .pllSourceSelect, .divFieldLow, .divFieldHigh, .pllOn,
    .oscDetectEnable, .onchipOscSelectWr, .onchipOscSelectVal, .oscDetectFlagClr, .oscDetectResponse,
    .waitInstr, .hwIrq, .subOscRun_r, .mainOscRun_r, .onchipOscRun_r, .cpuClkSrc_r, .cpuDivRatio_r,
    .div8Status_r, .onchipOscSelect_r, .oscDetectFlag_r, .mainClkStopped_r, .oscDetectIrq_r,
    .oscStopReset_r, .powerMode_r, .cpuClkGate);
  cmosd_xtal_model xtal (.run(mainOscRun_r), .fail(fail), .oscOut(mainOscIn));
  // 10 MHz clock
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  task cmp(input [4:0] got, input [4:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task close_out;
  begin
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // bounded wait; a pulse is seen at the falling edge
  task waitIrq;
  begin
    for (i = 0; i < 60 && oscDetectIrq_r !== 1'b1; i = i + 1)
      @(negedge ref_clk);
  end
  endtask
  function [4:0] expRatio(input a8, input h, input l);
    expRatio = a8 ? 5'h08 : ({h, l} == 2'h3 ? 5'h10 : 5'h01 << {h, l});
  endfunction
  function [1:0] expSrc(input s, input o, input p);
    expSrc = s ? 2'h3 : (o ? 2'h2 : (p ? 2'h1 : 2'h0));
  endfunction
  // main sequence
  initial
  begin
    r = $urandom(72513);
    repeat (6) @(negedge ref_clk);
    cmp(cpuDivRatio_r, 5'h08);
    rstn = 1;
    for (k = 0; k < 40; k = k + 1)
    begin
      r = $urandom;
      if (k % 2)
        subOscEnable = r[3];
      else
        {div8Select, divFieldHigh, divFieldLow} = r[6:4];
      {sysClkSubSelect, onchipOscSelectVal, pllOn} = r[2:0];
      pllSourceSelect = pllOn;
      mainOscStop = (k == 20);
      onchipOscSelectWr = 1;
      @(negedge ref_clk);
      onchipOscSelectWr = 0;
      @(negedge ref_clk);
      cmp(subOscRun_r, subOscEnable);
      cmp(mainOscRun_r, !mainOscStop);
      cmp(cpuDivRatio_r, expRatio(div8Select | mainOscStop, divFieldHigh, divFieldLow));
      cmp(cpuClkSrc_r, expSrc(sysClkSubSelect, onchipOscSelectVal, pllOn));
    end
    $display("random settings done");
    {sysClkSubSelect, pllOn, pllSourceSelect, div8Select, onchipOscSelectVal, onchipOscSelectWr} = 6'h01;
    for (k = 0; k < 2; k = k + 1)
    begin
      allClocksOffWr = (k == 0);
      waitInstr = (k == 1);
      @(negedge ref_clk);
      {allClocksOffWr, waitInstr, onchipOscSelectWr} = 3'h0;
      cmp({powerMode_r, cpuClkGate, div8Status_r}, k ? 4'h4 : 4'h9);
      hwIrq = 1;
      @(negedge ref_clk);
      hwIrq = 0;
      cmp({powerMode_r, cpuClkGate}, 3'h1);
    end
    $display("stop and wait done");
    {oscDetectResponse, oscDetectEnable} = 2'h3;
    repeat (20) @(negedge ref_clk);
    fail = 1;
    waitIrq;
    cmp(oscDetectIrq_r, 1'b1);
    cmp({oscDetectFlag_r, mainClkStopped_r, onchipOscSelect_r, onchipOscRun_r}, 4'hf);
    @(negedge ref_clk);
    cmp(cpuClkSrc_r, 2'h2);
    oscDetectFlagClr = 1;
    @(negedge ref_clk);
    oscDetectFlagClr = 0;
    fail = 0;
    waitIrq;
    cmp({oscDetectIrq_r, mainClkStopped_r}, 2'h2);
    // flag still set, later events silent
    fail = 1;
    repeat (30) @(negedge ref_clk);
    fail = 0;
    repeat (30) @(negedge ref_clk);
    {oscDetectFlagClr, oscDetectEnable} = 2'h2;
    @(negedge ref_clk);
    {oscDetectFlagClr, fail} = 2'h1;
    repeat (30) @(negedge ref_clk);
    cmp(oscDetectFlag_r, 1'b0);
    fail = 0;
    repeat (30) @(negedge ref_clk);
    $display("detect interrupt done");
    // reset response: a stop halts until the hardware reset
    {oscDetectResponse, oscDetectEnable} = 2'h1;
    repeat (20) @(negedge ref_clk);
    fail = 1;
    for (i = 0; i < 60 && powerMode_r !== 2'h3; i = i + 1)
      @(negedge ref_clk);
    cmp({powerMode_r, oscStopReset_r}, 3'h7);
    fail = 0;
    repeat (30) @(negedge ref_clk);
    cmp(powerMode_r, 2'h3);
    {rstn, oscDetectEnable} = 2'h0;
    @(negedge ref_clk);
    rstn = 1;
    @(negedge ref_clk);
    cmp({powerMode_r, oscStopReset_r}, 3'h0);
    $display("detect reset done");
    close_out;
  end
  // watchdog
  initial
  begin
    #1000000;
    n_errors = n_errors + 1;
    close_out;
  end
endmodule
